// ===== drc_control.sv
`timescale 1ns/1ns
`include "drc_params.svh"

// Operation
// - Waking from sleep by interrupt or watchdog leaves the control register unchanged.
// - Any device reset disables the converter.
// - Any device reset disconnects the converter from the analog output pin.
// - Any device reset clears the five-bit output range field.
// - Bit 7 turns the converter on when one and off when zero.
// - Bit 6 picks the positive source for low power when one, the negative when zero.
// - Bit 5 routes the converter level onto the analog pin when one and bit 7 is one, off when zero.
// - Bits 3:2 pick supply for 00, external positive pin for 01, fixed buffer for 10.
// - Bit 0 picks the external negative pin when one and ground when zero.
// - Bits 4 and 1 ignore writes and read as zero.
// - Implemented control bits are read/write and reset to zero on every reset.
module drc_control (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST,
  input  wire logic                 I_SLEEP,
  input  wire logic [11:0]          I_AWADDR,
  input  wire logic                 I_AWVALID,
  output logic                      O_AWREADY,
  input  wire logic [31:0]          I_WDATA,
  input  wire logic [3:0]           I_WSTRB,
  input  wire logic                 I_WVALID,
  output logic                      O_WREADY,
  output logic [1:0]                O_BRESP,
  output logic                      O_BVALID,
  input  wire logic                 I_BREADY,
  input  wire logic [11:0]          I_ARADDR,
  input  wire logic                 I_ARVALID,
  output logic                      O_ARREADY,
  output logic [31:0]               O_RDATA,
  output logic [1:0]                O_RRESP,
  output logic                      O_RVALID,
  input  wire logic                 I_RREADY,
  output logic                      O_CONVERTER_ENABLE,
  output logic                      O_LOW_POWER_SOURCE_SELECT,
  output logic                      O_ANALOG_PIN_OUTPUT_ENABLE,
  output drc_pkg::drc_pss_type      O_POSITIVE_SOURCE_SELECT,
  output logic                      O_NEGATIVE_SOURCE_SELECT,
  output logic [4:0]                O_OUTPUT_RANGE_SELECT,
  output logic                      O_RESERVED_CODE_SEEN
);
  import drc_pkg::*;

  // Address decode shared by both channels
  function automatic logic [1:0] decode(input logic [11:0] addr);
    case (addr)
      `DRC_ADDR_CONTROL: decode = 2'h1;
      `DRC_ADDR_RANGE:   decode = 2'h2;
      `DRC_ADDR_STATUS:  decode = 2'h3;
      default:           decode = 2'h0;
    endcase
  endfunction

  drc_wstate_type wst_r;
  drc_wstate_type wst_nxt;
  logic           aw_held_r;
  logic           aw_held_nxt;
  logic [11:0]    awaddr_r;
  logic [11:0]    awaddr_nxt;
  logic           w_held_r;
  logic           w_held_nxt;
  logic [7:0]     wdata_r;
  logic [7:0]     wdata_nxt;
  logic           wstrb_r;
  logic           wstrb_nxt;
  logic [1:0]     bresp_r;
  logic [1:0]     bresp_nxt;
  logic           ctl_we;
  logic           rng_we;
  logic [1:0]     wsel;
  logic           resv_r;
  logic           resv_nxt;
  logic           awready_r;
  logic           awready_nxt;
  logic           wready_r;
  logic           wready_nxt;
  logic           bvalid_r;
  logic           bvalid_nxt;

  drc_rstate_type rst_r;
  drc_rstate_type rst_nxt;
  logic [31:0]    rdata_r;
  logic [31:0]    rdata_nxt;
  logic [1:0]     rresp_r;
  logic [1:0]     rresp_nxt;
  logic           arready_r;
  logic           arready_nxt;
  logic           rvalid_r;
  logic           rvalid_nxt;

  logic [7:0]     ctl;
  logic [4:0]     rng;

  // Control and range storage
  drc_reg_store u_store (
    .i_clk    (I_CLK),
    .i_rst    (I_RST),
    .i_ctl_we (ctl_we),
    .i_rng_we (rng_we),
    .i_wdata  (wdata_r),
    .o_ctl    (ctl),
    .o_rng    (rng)
  );

  assign wsel = decode(awaddr_r);

  // Write channel: take address and data in any order, then respond
  always_comb begin
    wst_nxt     = wst_r;
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bresp_nxt   = bresp_r;
    ctl_we      = 1'b0;
    rng_we      = 1'b0;
    resv_nxt    = resv_r;
    case (wst_r)
      DRC_W_IDLE: begin
        if (I_AWVALID && !aw_held_r) begin
          aw_held_nxt = 1'b1;
          awaddr_nxt  = I_AWADDR;
        end
        if (I_WVALID && !w_held_r) begin
          w_held_nxt = 1'b1;
          wdata_nxt  = I_WDATA[7:0];
          wstrb_nxt  = I_WSTRB[0];
        end
        if (aw_held_r && w_held_r) begin
          ctl_we      = (wsel == 2'h1) && wstrb_r;
          rng_we      = (wsel == 2'h2) && wstrb_r;
          bresp_nxt   = (wsel == 2'h0) ? `DRC_RESP_SLVERR : `DRC_RESP_OKAY;
          // Flag a reserved positive source code written by software
          if (ctl_we && (wdata_r[`DRC_BIT_PSS_HI:`DRC_BIT_PSS_LO] == `DRC_PSS_RESERVED)) begin
            resv_nxt = 1'b1;
          end
          aw_held_nxt = 1'b0;
          w_held_nxt  = 1'b0;
          wst_nxt     = DRC_W_RESP;
        end
      end
      DRC_W_RESP: begin
        if (I_BREADY) begin
          wst_nxt = DRC_W_IDLE;
        end
      end
      default: wst_nxt = DRC_W_IDLE;
    endcase
    // Handshake flags follow the next state so they leave a flop
    awready_nxt = (wst_nxt == DRC_W_IDLE) && !aw_held_nxt;
    wready_nxt  = (wst_nxt == DRC_W_IDLE) && !w_held_nxt;
    bvalid_nxt  = (wst_nxt == DRC_W_RESP);
  end

  // Write channel registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wst_r     <= DRC_W_IDLE;
      aw_held_r <= 1'b0;
      awaddr_r  <= 12'h000;
      w_held_r  <= 1'b0;
      wdata_r   <= 8'h00;
      wstrb_r   <= 1'b0;
      bresp_r   <= `DRC_RESP_OKAY;
      resv_r    <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
    end else begin
      wst_r     <= wst_nxt;
      aw_held_r <= aw_held_nxt;
      awaddr_r  <= awaddr_nxt;
      w_held_r  <= w_held_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bresp_r   <= bresp_nxt;
      resv_r    <= resv_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
    end
  end

  // Read channel: one-cycle decode, data held until taken
  always_comb begin
    rst_nxt   = rst_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rst_r)
      DRC_R_IDLE: begin
        if (I_ARVALID) begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `DRC_RESP_OKAY;
          case (decode(I_ARADDR))
            2'h1:    rdata_nxt[7:0] = ctl & `DRC_CONTROL_MASK;
            2'h2:    rdata_nxt[4:0] = rng;
            2'h3:    rdata_nxt[0]   = I_SLEEP;
            default: rresp_nxt      = `DRC_RESP_SLVERR;
          endcase
          rst_nxt = DRC_R_DATA;
        end
      end
      DRC_R_DATA: begin
        if (I_RREADY) begin
          rst_nxt = DRC_R_IDLE;
        end
      end
      default: rst_nxt = DRC_R_IDLE;
    endcase
    arready_nxt = (rst_nxt == DRC_R_IDLE);
    rvalid_nxt  = (rst_nxt == DRC_R_DATA);
  end

  // Read channel registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rst_r   <= DRC_R_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `DRC_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end else begin
      rst_r   <= rst_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
    end
  end

  // Converter controls registered from the stored fields
  logic                 en_r;
  logic                 lps_r;
  logic                 oe_r;
  drc_pss_type          pss_r;
  logic                 nss_r;
  logic [4:0]           rng_out_r;
  logic                 en_nxt;
  logic                 lps_nxt;
  logic                 oe_nxt;
  drc_pss_type          pss_nxt;
  logic                 nss_nxt;
  logic [4:0]           rng_out_nxt;

  // Write data bypass so outputs move on the same edge as the register write
  always_comb begin
    logic [7:0] c;
    c = ctl;
    if (ctl_we) begin
      c = wdata_r & `DRC_CONTROL_MASK;
    end
    rng_out_nxt = rng_we ? wdata_r[4:0] : rng;
    en_nxt      = c[`DRC_BIT_ENABLE];
    lps_nxt     = c[`DRC_BIT_LPS];
    oe_nxt      = c[`DRC_BIT_PIN_OE] & c[`DRC_BIT_ENABLE];
    pss_nxt     = drc_pss_type'(c[`DRC_BIT_PSS_HI:`DRC_BIT_PSS_LO]);
    nss_nxt     = c[`DRC_BIT_NSS];
  end

  // Output registers; cleared by any reset
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      en_r      <= 1'b0;
      lps_r     <= 1'b0;
      oe_r      <= 1'b0;
      pss_r     <= DRC_PSS_SUPPLY;
      nss_r     <= 1'b0;
      rng_out_r <= `DRC_RANGE_RESET;
    end else begin
      en_r      <= en_nxt;
      lps_r     <= lps_nxt;
      oe_r      <= oe_nxt;
      pss_r     <= pss_nxt;
      nss_r     <= nss_nxt;
      rng_out_r <= rng_out_nxt;
    end
  end

  // Bus and converter outputs
  assign O_AWREADY                  = awready_r;
  assign O_WREADY                   = wready_r;
  assign O_BVALID                   = bvalid_r;
  assign O_BRESP                    = bresp_r;
  assign O_ARREADY                  = arready_r;
  assign O_RVALID                   = rvalid_r;
  assign O_RDATA                    = rdata_r;
  assign O_RRESP                    = rresp_r;
  assign O_CONVERTER_ENABLE         = en_r;
  assign O_LOW_POWER_SOURCE_SELECT  = lps_r;
  assign O_ANALOG_PIN_OUTPUT_ENABLE = oe_r;
  assign O_POSITIVE_SOURCE_SELECT   = pss_r;
  assign O_NEGATIVE_SOURCE_SELECT   = nss_r;
  assign O_OUTPUT_RANGE_SELECT      = rng_out_r;
  assign O_RESERVED_CODE_SEEN       = resv_r;

endmodule // drc_control

// ===== drc_params.svh
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

// Register byte addresses
`define DRC_ADDR_CONTROL      12'h000
`define DRC_ADDR_RANGE        12'h004
`define DRC_ADDR_STATUS       12'h008

// Control register field positions
`define DRC_BIT_ENABLE        7
`define DRC_BIT_LPS           6
`define DRC_BIT_PIN_OE        5
`define DRC_BIT_PSS_HI        3
`define DRC_BIT_PSS_LO        2
`define DRC_BIT_NSS           0

// Writable bits and reset values of the control and range registers
`define DRC_CONTROL_MASK      8'hed
`define DRC_CONTROL_RESET     8'h00
`define DRC_RANGE_RESET       5'h00
`define DRC_RANGE_MASK        8'h1f

// Reserved positive source code
`define DRC_PSS_RESERVED      2'h3

// AXI responses
`define DRC_RESP_OKAY         2'h0
`define DRC_RESP_SLVERR       2'h2

`endif

// ===== drc_pkg.sv
package drc_pkg;

  typedef enum logic [1:0] {
    DRC_PSS_SUPPLY,
    DRC_PSS_EXT_REF,
    DRC_PSS_FIXED_BUF,
    DRC_PSS_RESV
  } drc_pss_type;

  typedef enum logic {
    DRC_W_IDLE,
    DRC_W_RESP
  } drc_wstate_type;

  typedef enum logic {
    DRC_R_IDLE,
    DRC_R_DATA
  } drc_rstate_type;

endpackage

// ===== drc_reg_store.sv
`timescale 1ns/1ns
`include "drc_params.svh"

// Holds the control and range registers; reset only on device reset
module drc_reg_store (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ctl_we,
  input  wire logic       i_rng_we,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_ctl,
  output logic      [4:0] o_rng
);

  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic [4:0] rng_r;
  logic [4:0] rng_nxt;

  // Next values; unimplemented bits never stored
  always_comb begin
    ctl_nxt = ctl_r;
    rng_nxt = rng_r;
    if (i_ctl_we) begin
      ctl_nxt = i_wdata & `DRC_CONTROL_MASK;
    end
    if (i_rng_we) begin
      rng_nxt = i_wdata[4:0];
    end
  end

  // Register; sleep and wake have no effect here
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl_r <= `DRC_CONTROL_RESET;
      rng_r <= `DRC_RANGE_RESET;
    end else begin
      ctl_r <= ctl_nxt;
      rng_r <= rng_nxt;
    end
  end

  assign o_ctl = ctl_r;
  assign o_rng = rng_r;

endmodule // drc_reg_store

// ===== drc_control_monitor.sv
`timescale 1ns/1ns
// Port checks on the reference control block
module drc_control_monitor (
  input wire logic       I_CLK,
  input wire logic       I_RST,
  input wire logic       I_AWVALID,
  input wire logic       O_AWREADY,
  input wire logic       I_WVALID,
  input wire logic       O_WREADY,
  input wire logic       O_BVALID,
  input wire logic       I_ARVALID,
  input wire logic       O_ARREADY,
  input wire logic       O_RVALID,
  input wire logic       O_CONVERTER_ENABLE,
  input wire logic       O_ANALOG_PIN_OUTPUT_ENABLE,
  input wire logic [4:0] O_OUTPUT_RANGE_SELECT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // Outputs cleared once reset lets go
  enable_reset_a: assert property ($fell(I_RST) |-> !O_CONVERTER_ENABLE)
    else $error("converter on after reset");
  pin_reset_a: assert property ($fell(I_RST) |-> !O_ANALOG_PIN_OUTPUT_ENABLE)
    else $error("pin driven after reset");
  range_reset_a: assert property ($fell(I_RST) |-> O_OUTPUT_RANGE_SELECT == 5'h00)
    else $error("range not cleared");
  // Pin is never driven by a disabled converter
  pin_needs_en_a: assert property (O_ANALOG_PIN_OUTPUT_ENABLE |-> O_CONVERTER_ENABLE)
    else $error("pin driven while off");
  // Outputs move only with a committed write, not with sleep
  out_commit_a: assert property ($changed({O_CONVERTER_ENABLE, O_OUTPUT_RANGE_SELECT})
    |-> $rose(O_BVALID)) else $error("output moved without write");
  write_resp_a: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
    |-> ##[1:3] O_BVALID) else $error("write response late");
  busy_refuse_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while busy");
  read_resp_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
    else $error("read response late");
  cover property (I_ARVALID && O_ARREADY);
  cover property ($rose(O_CONVERTER_ENABLE));
  cover property ($rose(O_ANALOG_PIN_OUTPUT_ENABLE));
endmodule // drc_control_monitor

// ===== tb_drc_control.sv
`timescale 1ns/1ns
module tb_drc_control;
  import drc_pkg::*;
  logic        clk = 0, rst = 1, sleep = 0, awvalid = 0, wvalid = 0;
  logic        bready = 0, arvalid = 0, rready = 0, seen_m;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 0;
  logic        awready, wready, bvalid, arready, rvalid, en, lps, pin, nss, seen;
  logic [1:0]  bresp, rresp;
  logic [4:0]  rng, rng_m;
  logic [7:0]  ctl_m;
  drc_pss_type pss;
  logic [33:0] bq[$], rq[$];
  int          err_total = 0, tests_run = 0, cyc = 0;
  logic [33:0] outs;

  // Observed outputs in the layout of the write notes
  assign outs = {20'h0, bresp, en, lps, pin, pss, nss, seen, rng};

  always #50 clk = ~clk;

  drc_control i_drc_control (.I_CLK(clk), .I_RST(rst), .I_SLEEP(sleep),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .O_CONVERTER_ENABLE(en), .O_LOW_POWER_SOURCE_SELECT(lps),
    .O_ANALOG_PIN_OUTPUT_ENABLE(pin), .O_POSITIVE_SOURCE_SELECT(pss),
    .O_NEGATIVE_SOURCE_SELECT(nss), .O_OUTPUT_RANGE_SELECT(rng),
    .O_RESERVED_CODE_SEEN(seen));

  task chk(input string n, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task complete_run;
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Write with both channels offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, hit;
    aw = 1;
    w = 1;
    hit = (a == 12'h000) || (a == 12'h004) || (a == 12'h008);
    if (a == 12'h000 && s[0]) begin
      ctl_m = d[7:0] & 8'hed;
      seen_m = seen_m | (d[3:2] == 2'h3);
    end
    if (a == 12'h004 && s[0]) rng_m = d[4:0];
    bq.push_back({20'h0, hit ? 2'h0 : 2'h2, ctl_m[7:6], ctl_m[5] & ctl_m[7],
      ctl_m[3:2], ctl_m[0], seen_m, rng_m});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end while (aw || w || !bvalid);
    bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a);
    logic ar, hit;
    ar = 1;
    hit = (a == 12'h000) || (a == 12'h004) || (a == 12'h008);
    rq.push_back({hit ? 2'h0 : 2'h2, (a == 12'h000) ? {24'h0, ctl_m} :
      (a == 12'h004) ? {27'h0, rng_m} : (a == 12'h008) ? {31'h0, sleep} : 32'h0});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (ar && arready) begin
        ar = 0;
        arvalid <= 0;
      end
    end while (ar || !rvalid);
    rready <= 0;
  endtask

  // Compares each response with the oldest note
  always @(posedge clk) begin
    cyc++;
    if (bvalid && bready) begin
      chk("outputs", bq.pop_front(), outs);
    end
    if (rvalid && rready) begin
      chk("read", rq.pop_front(), {rresp, rdata});
    end
    if (cyc == 2000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    logic [31:0] v;
    v = $urandom(32'h59c81f0d);
    ctl_m = 0;
    rng_m = 0;
    seen_m = 0;
    repeat (5) @(posedge clk);
    rst <= 0;
    // Reset state and unmapped place
    wr(12'h000, 32'h0, 4'h0);
    rd(12'h000);
    rd(12'h004);
    wr(12'h00c, 32'hff, 4'hf);
    rd(12'h00c);
    wr(12'h008, 32'hff, 4'hf);
    // Each legal source code, random remaining bits
    for (int k = 0; k < 3; k++) begin
      v = $urandom;
      wr(12'h000, {v[31:4], k[1:0], v[1:0]}, 4'hf);
      rd(12'h000);
      wr(12'h004, v, 4'hf);
      rd(12'h004);
    end
    // Deliberate reserved code raises the sticky flag
    wr(12'h000, 32'h0c, 4'h1);
    wr(12'h000, 32'h65, 4'hf);
    wr(12'h000, 32'hf7, 4'hf);
    wr(12'h004, 32'h15, 4'h1);
    wr(12'h000, 32'hff, 4'h0);
    // Sleep keeps the registers
    sleep <= 1;
    repeat (3) @(posedge clk);
    rd(12'h008);
    rd(12'h000);
    rd(12'h004);
    sleep <= 0;
    // Reset in mid-run
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    ctl_m = 0;
    rng_m = 0;
    seen_m = 0;
    wr(12'h000, 32'h0, 4'h0);
    rd(12'h004);
    rd(12'h000);
    complete_run();
  end
endmodule // tb_drc_control

bind drc_control drc_control_monitor i_drc_control_monitor (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
  .O_BVALID(O_BVALID), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID),
  .O_CONVERTER_ENABLE(O_CONVERTER_ENABLE),
  .O_ANALOG_PIN_OUTPUT_ENABLE(O_ANALOG_PIN_OUTPUT_ENABLE),
  .O_OUTPUT_RANGE_SELECT(O_OUTPUT_RANGE_SELECT));
